// *** core/apsr_pkg.sv ***
// apsr_pkg: offsets, field positions, reset values and carrier types for the
// analog compare / port direction / serial control register bank.
// assumes a 32-bit AXI4-Lite register bus, one aligned word per register.
package apsr_pkg;
    // printed offsets are register indices; byte address is four times each
    localparam logic [7:0] IDX_CHAN_SEL  = 8'h5c;
    localparam logic [7:0] IDX_REF_LEVEL = 8'h5d;
    localparam logic [7:0] IDX_CMP_START = 8'h5e;
    localparam logic [7:0] IDX_CMP_RES   = 8'h5f;
    localparam logic [7:0] IDX_SER_MODE  = 8'h60;
    localparam logic [7:0] IDX_SER_CLK   = 8'h61;
    localparam logic [7:0] IDX_DIR_B     = 8'h6e;
    localparam logic [7:0] IDX_DIR_CD    = 8'h6f;
    localparam int         ADDR_W        = 10;

    // field positions
    localparam int POS_CMP_START  = 0;
    localparam int POS_CMP_RES    = 0;
    localparam int POS_SER_RUN    = 0;
    localparam int POS_SER_OUTPIN = 1;
    localparam int POS_SER_DIR    = 2;

    // reset values
    localparam logic [3:0] RST_REG4 = 4'h0;

    // comparator channel codes
    localparam logic [1:0] CHAN_NONE   = 2'h0;
    localparam logic [1:0] CHAN_FIRST  = 2'h1;

    // serial clock codes and shift rates
    localparam logic [1:0] SCLK_EXT    = 2'h0;
    localparam logic [1:0] SCLK_12K5   = 2'h1;
    localparam logic [1:0] SCLK_18K75  = 2'h2;
    localparam logic [1:0] SCLK_37K5   = 2'h3;
    localparam real        CLK_HZ      = 125.0e6;
    localparam real        RATE_12K5   = 12.5e3;
    localparam real        RATE_18K75  = 18.75e3;
    localparam real        RATE_37K5   = 37.5e3;
    // half period in system clocks, rounded down (never longer than exact)
    localparam int HALF_12K5  = int'($floor(CLK_HZ / (2.0 * RATE_12K5)));
    localparam int HALF_18K75 = int'($floor(CLK_HZ / (2.0 * RATE_18K75)));
    localparam int HALF_37K5  = int'($floor(CLK_HZ / (2.0 * RATE_37K5)));

    // comparison settle time in system clocks
    localparam int CMP_SETTLE = 4;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] channel;
        logic [3:0] ref_code;
        logic       ser_dir;
        logic       ser_outpin;
        logic       ser_run;
        logic [1:0] ser_clk;
    } apsr_ctrl_t;
endpackage : apsr_pkg

// *** core/apsr_regs.sv ***
// apsr_regs: AXI4-Lite register bank for comparator channel/reference/start,
// port direction bits and serial mode/clock selection.
// assumes an external analog comparator reporting input above reference
// and a serial shifter that consumes the drive and clock outputs.
//
// Overview of operation
// - channel code picks none, first, second pin
// - reference level is (code+0.5)/16 of supply
// - each direction bit: 0 input, 1 output
// - serial direction: 0 input, 1 output
// - out-pin bit routes serial data or port when serial direction is output
// - clock code: external, 12.5, 18.75, 37.5 kHz
`timescale 1ns/10ps
module apsr_regs
    import apsr_pkg::*;
#(
    parameter int HALF_A = HALF_12K5,
    parameter int HALF_B = HALF_18K75,
    parameter int HALF_C = HALF_37K5
)
(
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // axi4-lite write address, data and response
    input  wire logic [apsr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // axi4-lite read
    input  wire logic [apsr_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // analog comparator
    input  wire logic                      comparator_above,
    output logic                           analog_pin_first_sel,
    output logic                           analog_pin_second_sel,
    output logic [3:0]                     reference_code,
    output logic                           comparator_enable,
    // general-purpose port direction
    output logic [3:0]                     group_b_dir,
    output logic [3:0]                     group_cd_dir,
    // serial interface
    output logic                           shared_serial_data_oe,
    output logic                           serial_out_pin_route,
    output logic                           serial_run,
    output logic                           serial_ext_clock,
    output logic                           serial_shift_clock
);
    // the divider counts in 16 bits and the settle counter in 3
    if (HALF_A < 1 || HALF_A > 65535 || HALF_B < 1 || HALF_B > 65535 ||
        HALF_C < 1 || HALF_C > 65535 || CMP_SETTLE < 1 || CMP_SETTLE > 8)
    begin : g_range_check
        $error("apsr_regs: half period or settle count out of range");
    end

    apsr_ctrl_t   ctrl;
    logic [3:0]   dir_b;
    logic [3:0]   dir_cd;
    logic         cmp_result;
    // kept apart from ctrl so that only the compare process writes it
    logic         cmp_run;
    logic [2:0]   settle_cnt;
    logic         aw_held;
    logic         w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         do_write;
    logic [7:0]   w_idx;
    logic [7:0]   r_idx;
    logic         w_hit;
    logic         r_hit;
    logic [31:0]  next_rdata;
    logic [15:0]  div_cnt;
    logic [15:0]  div_half;

    // write channel: address and data taken independently, response after both
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign w_idx         = aw_addr[ADDR_W-1:2];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        else if (do_write)
            aw_held <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (do_write)
            w_held <= 1'b0;
    end

    always_comb
    begin
        case (w_idx)
            IDX_CHAN_SEL, IDX_REF_LEVEL, IDX_CMP_START, IDX_CMP_RES,
            IDX_SER_MODE, IDX_SER_CLK, IDX_DIR_B, IDX_DIR_CD: w_hit = 1'b1;
            default: w_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= w_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // only byte lane 0 carries register bits; upper bits are dropped
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl.channel    <= RST_REG4[1:0];
            ctrl.ref_code   <= RST_REG4;
            ctrl.ser_dir    <= RST_REG4[0];
            ctrl.ser_outpin <= RST_REG4[0];
            ctrl.ser_run    <= RST_REG4[0];
            ctrl.ser_clk    <= RST_REG4[1:0];
            dir_b           <= RST_REG4;
            dir_cd          <= RST_REG4;
        end
        else if (do_write && w_strb[0])
        begin
            case (w_idx)
                IDX_CHAN_SEL:  ctrl.channel <= w_data[1:0];
                IDX_REF_LEVEL: ctrl.ref_code <= w_data[3:0];
                IDX_SER_MODE:
                begin
                    ctrl.ser_dir    <= w_data[POS_SER_DIR];
                    ctrl.ser_outpin <= w_data[POS_SER_OUTPIN];
                    ctrl.ser_run    <= w_data[POS_SER_RUN];
                end
                IDX_SER_CLK:   ctrl.ser_clk <= w_data[1:0];
                IDX_DIR_B:     dir_b <= w_data[3:0];
                IDX_DIR_CD:    dir_cd <= w_data[3:0];
                default:       ;
            endcase
        end
    end

    // compare start: written 1 runs the comparator until it settles, then
    // the result is latched; written 0 stops it at once
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cmp_run    <= 1'b0;
            settle_cnt <= '0;
            cmp_result <= 1'b0;
        end
        else if (do_write && w_strb[0] && w_idx == IDX_CMP_START)
        begin
            cmp_run    <= w_data[POS_CMP_START];
            settle_cnt <= '0;
        end
        else if (cmp_run)
        begin
            if (32'(settle_cnt) == CMP_SETTLE - 1)
            begin
                cmp_run      <= 1'b0;
                // no channel selected compares nothing and reads 0
                cmp_result   <= (ctrl.channel != CHAN_NONE) && comparator_above;
            end
            else
                settle_cnt <= settle_cnt + 3'h1;
        end
    end

    // read channel
    assign s_axi_arready = !s_axi_rvalid;
    assign r_idx         = s_axi_araddr[ADDR_W-1:2];

    always_comb
    begin
        next_rdata = 32'h0;
        r_hit      = 1'b1;
        case (r_idx)
            IDX_CHAN_SEL:  next_rdata[1:0] = ctrl.channel;
            IDX_REF_LEVEL: next_rdata[3:0] = ctrl.ref_code;
            IDX_CMP_START: next_rdata[POS_CMP_START] = cmp_run;
            IDX_CMP_RES:   next_rdata[POS_CMP_RES] = cmp_result;
            IDX_SER_MODE:
            begin
                next_rdata[POS_SER_DIR]    = ctrl.ser_dir;
                next_rdata[POS_SER_OUTPIN] = ctrl.ser_outpin;
                next_rdata[POS_SER_RUN]    = ctrl.ser_run;
            end
            IDX_SER_CLK:   next_rdata[1:0] = ctrl.ser_clk;
            IDX_DIR_B:     next_rdata[3:0] = dir_b;
            IDX_DIR_CD:    next_rdata[3:0] = dir_cd;
            default:       r_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= r_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // internal shift clock divider; held idle while serial is stopped
    always_comb
    begin
        case (ctrl.ser_clk)
            SCLK_12K5:  div_half = 16'(HALF_A);
            SCLK_18K75: div_half = 16'(HALF_B);
            SCLK_37K5:  div_half = 16'(HALF_C);
            default:    div_half = 16'h1;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_cnt            <= '0;
            serial_shift_clock <= 1'b1;
        end
        else if (!ctrl.ser_run || ctrl.ser_clk == SCLK_EXT)
        begin
            div_cnt            <= '0;
            serial_shift_clock <= 1'b1;
        end
        else if (div_cnt >= div_half - 16'h1)
        begin
            div_cnt            <= '0;
            serial_shift_clock <= !serial_shift_clock;
        end
        else
            div_cnt <= div_cnt + 16'h1;
    end

    // outputs
    assign analog_pin_first_sel  = ctrl.channel == CHAN_FIRST;
    assign analog_pin_second_sel = ctrl.channel[1];
    assign reference_code        = ctrl.ref_code;
    assign comparator_enable     = cmp_run;
    assign group_b_dir           = dir_b;
    assign group_cd_dir          = dir_cd;
    assign shared_serial_data_oe = ctrl.ser_dir;
    assign serial_out_pin_route  = ctrl.ser_dir && ctrl.ser_outpin;
    assign serial_run            = ctrl.ser_run;
    assign serial_ext_clock      = ctrl.ser_clk == SCLK_EXT;
endmodule : apsr_regs

// *** tb/apsr_checker.sv ***
// apsr_checker: timing and output relations of the register bank.
// assumes it is bound to apsr_regs and sees only that module's ports.
`timescale 1ns/10ps
module apsr_checker
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // block outputs
    input wire logic        analog_pin_first_sel,
    input wire logic        analog_pin_second_sel,
    input wire logic        comparator_enable,
    input wire logic        shared_serial_data_oe,
    input wire logic        serial_out_pin_route,
    input wire logic        serial_run,
    input wire logic        serial_ext_clock,
    input wire logic        serial_shift_clock
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // a compare lasts at most four cycles once started
    sequence s_run4; comparator_enable [*4]; endsequence
    sequence s_stopped; !serial_run [*2]; endsequence
    property p_one_pin; !(analog_pin_first_sel && analog_pin_second_sel); endproperty
    a_one_pin: assert property (p_one_pin) else $error("two pins selected");
    property p_cmp_len; s_run4 |=> !comparator_enable; endproperty
    a_cmp_len: assert property (p_cmp_len) else $error("compare too long");
    property p_cmp_cause; $rose(comparator_enable) |-> $rose(s_axi_bvalid); endproperty
    a_cmp_cause: assert property (p_cmp_cause) else $error("compare without write");
    property p_route; serial_out_pin_route |-> shared_serial_data_oe; endproperty
    a_route: assert property (p_route) else $error("route in input mode");
    property p_stop_idle; s_stopped |-> serial_shift_clock; endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("clock runs when stopped");
    property p_ext_idle; serial_ext_clock [*2] |-> serial_shift_clock; endproperty
    a_ext_idle: assert property (p_ext_idle) else $error("internal clock on external");
    property p_rdata_pad; s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0; endproperty
    a_rdata_pad: assert property (p_rdata_pad) else $error("upper read bits set");
    property p_ar_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_ar_answer: assert property (p_ar_answer) else $error("read answer late");
endmodule : apsr_checker

bind apsr_regs apsr_checker chk_u (.aclk, .aresetn, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .analog_pin_first_sel,
    .analog_pin_second_sel, .comparator_enable, .shared_serial_data_oe,
    .serial_out_pin_route, .serial_run, .serial_ext_clock, .serial_shift_clock);

// *** tb/apsr_regs_test.sv ***
// apsr_regs_test: directed bench for the register bank over AXI4-Lite.
// assumes shift-clock half periods shortened to 2, 3 and 4 cycles.
`timescale 1ns/10ps
module apsr_regs_test;
    import apsr_pkg::*;
    localparam int         H [4]  = '{0, 2, 3, 4};
    localparam logic [7:0] IX [8] = '{IDX_CHAN_SEL, IDX_REF_LEVEL, IDX_CMP_START,
        IDX_CMP_RES, IDX_SER_MODE, IDX_SER_CLK, IDX_DIR_B, IDX_DIR_CD};
    localparam logic [3:0] M [8]  = '{4'h3, 4'hf, 4'h1, 4'h0, 4'h7, 4'h3, 4'hf, 4'hf};
    logic              aclk = 1'b0, aresetn = 1'b0;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, comparator_above = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]        s_axi_wstrb = '0, reference_code, group_b_dir, group_cd_dir;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic              s_axi_rvalid, analog_pin_first_sel, analog_pin_second_sel;
    logic              comparator_enable, shared_serial_data_oe, serial_out_pin_route;
    logic              serial_run, serial_ext_clock, serial_shift_clock;
    int                errors = 0, n_compared = 0;

    apsr_regs #(.HALF_A(H[1]), .HALF_B(H[2]), .HALF_C(H[3])) dut_u (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .comparator_above, .analog_pin_first_sel,
        .analog_pin_second_sel, .reference_code, .comparator_enable, .group_b_dir,
        .group_cd_dir, .shared_serial_data_oe, .serial_out_pin_route, .serial_run,
        .serial_ext_clock, .serial_shift_clock);

    always #4 aclk = ~aclk;

    function automatic logic [ADDR_W-1:0] ba(input int i);
        return {IX[i], 2'b00};
    endfunction : ba

    task automatic conclude;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // a wait that used up its bound ends the run
    task automatic lim(input int n);
        if (n >= 99)
        begin
            errors++;
            conclude();
        end
    endtask : lim

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        logic ta, tw, aw, w;
        int   n;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        aw = 1'b1;
        w  = 1'b1;
        for (n = 0; n < 99 && (aw || w); n++)
        begin
            @(negedge aclk);
            ta = aw && s_axi_awready;
            tw = w && s_axi_wready;
            @(posedge aclk);
            aw = aw && !ta;
            w  = w && !tw;
            s_axi_awvalid <= aw;
            s_axi_wvalid  <= w;
        end
        lim(n);
        @(negedge aclk);
        for (n = 0; n < 99 && s_axi_bvalid !== 1'b1; n++)
            @(negedge aclk);
        lim(n);
        chk($sformatf("bresp %h", a), s_axi_bresp, er);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp,
                      input logic [1:0] er);
        logic ta;
        int   n;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        ta = 1'b0;
        for (n = 0; n < 99 && !ta; n++)
        begin
            @(negedge aclk);
            ta = s_axi_arready;
            @(posedge aclk);
        end
        s_axi_arvalid <= 1'b0;
        lim(n);
        @(negedge aclk);
        for (n = 0; n < 99 && s_axi_rvalid !== 1'b1; n++)
            @(negedge aclk);
        lim(n);
        chk($sformatf("rdata %h", a), s_axi_rdata, exp);
        chk($sformatf("rresp %h", a), s_axi_rresp, er);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd

    // every register back to zero, serial clock outputs idle
    task automatic t_reset;
        for (int i = 0; i < 8; i++)
            rd(ba(i), 32'h0, RESP_OKAY);
        chk("idle clk", {serial_ext_clock, serial_shift_clock}, 2'h3);
    endtask : t_reset

    // all-ones into each register but compare start; only defined bits stick, result stays read-only
    task automatic t_rw;
        for (int i = 0; i < 8; i++)
        begin
            if (i == 2)
                continue;
            wr(ba(i), 32'hffffffff, 4'hf, RESP_OKAY);
            rd(ba(i), {28'h0, M[i]}, RESP_OKAY);
        end
        chk("ref", reference_code, 4'hf);
        chk("dir", {group_b_dir, group_cd_dir}, 8'hff);
        chk("ser", {shared_serial_data_oe, serial_out_pin_route, serial_run}, 3'h7);
        wr(ba(4), 32'h3, 4'hf, RESP_OKAY);
        chk("ser in", {shared_serial_data_oe, serial_out_pin_route, serial_run}, 3'h1);
    endtask : t_rw

    // unmapped place and a strobe-less write
    task automatic t_err;
        wr(10'h000, 32'h1, 4'hf, RESP_SLVERR);
        rd(10'h000, 32'h0, RESP_SLVERR);
        wr(ba(6), 32'h5, 4'hf, RESP_OKAY);
        wr(ba(6), 32'ha, 4'h0, RESP_OKAY);
        wr(ba(7), 32'ha, 4'hf, RESP_OKAY);
        chk("dir bits", {group_b_dir, group_cd_dir}, 8'h5a);
    endtask : t_err

    task automatic t_chan;
        for (int c = 0; c < 4; c++)
        begin
            wr(ba(0), c, 4'hf, RESP_OKAY);
            chk("pins", {analog_pin_first_sel, analog_pin_second_sel}, {c == 1, c >= 2});
        end
    endtask : t_chan

    // half period of the internal shift clock for each internal code
    task automatic t_clk;
        logic v;
        int   n;
        wr(ba(4), 32'h1, 4'hf, RESP_OKAY);
        for (int c = 0; c < 4; c++)
        begin
            wr(ba(5), c, 4'hf, RESP_OKAY);
            chk("ext", serial_ext_clock, c == 0);
            if (c == 0)
                continue;
            v = serial_shift_clock;
            for (n = 0; n < 99 && serial_shift_clock === v; n++)
                @(negedge aclk);
            lim(n);
            v = serial_shift_clock;
            for (n = 0; n < 99 && serial_shift_clock === v; n++)
                @(negedge aclk);
            chk("half", n, H[c]);
            lim(n);
        end
        wr(ba(4), 32'h0, 4'hf, RESP_OKAY);
        repeat (3) @(negedge aclk);
        chk("stopped", serial_shift_clock, 1'b1);
    endtask : t_clk

    task automatic t_cmp(input logic [1:0] ch, input logic above, input logic res);
        int n;
        wr(ba(0), ch, 4'hf, RESP_OKAY);
        comparator_above <= above;
        wr(ba(2), 32'h1, 4'hf, RESP_OKAY);
        @(negedge aclk);
        chk("running", comparator_enable, 1'b1);
        for (n = 0; n < 99 && comparator_enable !== 1'b0; n++)
            @(negedge aclk);
        lim(n);
        rd(ba(2), 32'h0, RESP_OKAY);
        rd(ba(3), res, RESP_OKAY);
    endtask : t_cmp

    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_rw();
        t_err();
        t_chan();
        t_clk();
        t_cmp(2'h1, 1'b1, 1'b1);
        t_cmp(2'h1, 1'b0, 1'b0);
        t_cmp(2'h0, 1'b1, 1'b0);
        t_cmp(2'h3, 1'b1, 1'b1);
        conclude();
    end
endmodule : apsr_regs_test
